//--- src/ccmse_top.sv
// The Avalon-MM interface to the registers was decided locally.
module ccmse_top
   import ccmse_pkg::*;
#(
   parameter int COARSE_CYC = UNIT_COARSE_CYC,
   parameter int FINE_CYC = UNIT_FINE_CYC,
   parameter int MSG_CYC = MSG_UNIT_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire ccmse_lines_t comp_raw,
   input wire ccmse_link_t link_evt,
   input wire logic [1:0] link_state,
   output logic irq
);
   // ********************************************************
   // Input synchronisers
   // ********************************************************
   ccmse_lines_t raw_s1, raw_s2;
   ccmse_link_t evt_s1, evt_s2, evt_d;
   logic [1:0] st_s1, st_s2;
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         raw_s1 <= '0;
         raw_s2 <= '0;
         evt_s1 <= '0;
         evt_s2 <= '0;
         evt_d <= '0;
         st_s1 <= '0;
         st_s2 <= '0;
      end else if (clk_en) begin
         raw_s1 <= comp_raw;
         raw_s2 <= raw_s1;
         evt_s1 <= link_evt;
         evt_s2 <= evt_s1;
         evt_d <= evt_s2;
         st_s1 <= link_state;
         st_s2 <= st_s1;
      end
   end
   ccmse_link_t evt_pulse;
   assign evt_pulse = evt_s2 & ~evt_d;

   // ********************************************************
   // Registers
   // ********************************************************
   logic [15:0] int_sts, next_int_sts, int_mask, next_int_mask;
   logic [7:0] ctl, next_ctl, dbclr1, next_dbclr1, dbclr2, next_dbclr2;
   logic [7:0] hit_deb, next_hit_deb, msg_deb, next_msg_deb;
   logic [7:0] chg1, next_chg1, chg2, next_chg2;
   ccmse_lines_t hits, next_hits;
   logic seen_valid, next_seen_valid;
   logic [31:0] rdata, next_rdata;
   logic ack, next_ack;
   logic [31:0] unit_cnt, next_unit_cnt;
   logic [7:0] tick_cnt, next_tick_cnt;
   ccmse_state_t st;

   function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] setb,
                                      input logic [7:0] clr);
      return setb | (cur & ~clr);
   endfunction

   function automatic logic [7:0] mix(input logic [7:0] deb, input logic [7:0] raw,
                                      input logic [7:0] en);
      return (deb & en) | (raw & ~en);
   endfunction

   logic role_src, standalone, comp_en, sink_alone;
   assign role_src = ctl[CTL_ROLE_SRC];
   assign standalone = ctl[CTL_STANDALONE];
   assign comp_en = ctl[CTL_COMP_EN];
   assign sink_alone = standalone & ~role_src;

   always_comb begin
      case (st_s2)
         2'h1: st = ccmse_attach_wait;
         2'h2: st = ccmse_attached;
         default: st = ccmse_unattached;
      endcase
   end

   // ********************************************************
   // Debounce timer
   // ********************************************************
   logic [31:0] unit_len, target;
   logic tick, update, active, hold;
   always_comb begin
      unit_len = ctl[CTL_UNIT_FINE] ? 32'(FINE_CYC) : 32'(COARSE_CYC);
      target = 32'(hit_deb);
      case (st)
         ccmse_unattached: begin
            unit_len = ctl[CTL_UNIT_FINE] ? 32'(FINE_CYC) : 32'(COARSE_CYC);
            target = 32'(hit_deb);
            hold = 1'b0;
         end
         ccmse_attach_wait: begin
            unit_len = 32'(MSG_CYC);
            target = 32'(msg_deb);
            hold = ~evt_s2.open_seen;
         end
         ccmse_attached: begin
            unit_len = 32'(MSG_CYC);
            target = 32'(msg_deb);
            hold = 1'b0;
         end
         default: begin
            hold = 1'b1;
         end
      endcase
      active = comp_en | standalone;
      tick = (unit_cnt + 32'h1 >= unit_len);
      next_unit_cnt = (!active || hold || tick) ? 32'h0 : unit_cnt + 32'h1;
      next_tick_cnt = tick_cnt;
      update = 1'b0;
      if (!active || hold) begin
         next_tick_cnt = 8'h00;
      end else if (tick) begin
         if (32'(tick_cnt) + 32'h1 >= target) begin
            update = 1'b1;
            next_tick_cnt = 8'h00;
         end else begin
            next_tick_cnt = tick_cnt + 8'h1;
         end
      end
   end

   // ********************************************************
   // Hits, changes and interrupt status
   // ********************************************************
   logic wr_hit, rd_hit;
   logic [11:0] idx;
   logic [15:0] wd;
   logic [7:0] set1, set2;
   logic [15:0] ev_set;
   assign idx = avs_address[ADDR_W-1:2];
   assign wr_hit = avs_write & ack;
   assign rd_hit = avs_read & ~ack;
   assign wd = {avs_byteenable[1] ? avs_writedata[15:8] : BYTE_ZERO,
                avs_byteenable[0] ? avs_writedata[7:0] : BYTE_ZERO};

   always_comb begin
      next_hits = hits;
      if (!standalone && !comp_en) begin
         next_hits.line1 = role_src ? HITS_RST_SRC : HITS_RST_SNK;
         next_hits.line2 = role_src ? HITS_RST_SRC : HITS_RST_SNK;
      end else if (update) begin
         next_hits.line1 = mix(raw_s2.line1, raw_s2.line1, dbclr1);
         next_hits.line2 = mix(raw_s2.line2, raw_s2.line2, dbclr2);
      end
      if ((standalone || comp_en) && !update) begin
         next_hits.line1 = mix(hits.line1, raw_s2.line1, dbclr1);
         next_hits.line2 = mix(hits.line2, raw_s2.line2, dbclr2);
      end
      next_seen_valid = seen_valid | ((standalone || comp_en) && update);
      set1 = (standalone || comp_en) ? (next_hits.line1 ^ hits.line1) : BYTE_ZERO;
      set2 = (standalone || comp_en) ? (next_hits.line2 ^ hits.line2) : BYTE_ZERO;
      next_chg1 = w1c(chg1, set1, (wr_hit && idx == IDX_L1_CHANGE) ? wd[7:0] : BYTE_ZERO);
      next_chg2 = w1c(chg2, set2, (wr_hit && idx == IDX_L2_CHANGE) ? wd[7:0] : BYTE_ZERO);
      ev_set = INT_RST;
      ev_set[BIT_VALID] = update && !seen_valid && (standalone || comp_en);
      ev_set[BIT_PULLUP] = sink_alone & evt_pulse.pullup_change;
      ev_set[BIT_DETACH] = standalone & evt_pulse.detach;
      ev_set[BIT_ATTACH] = standalone & evt_pulse.attach;
      next_int_sts = ev_set | (int_sts & ~((wr_hit && idx == IDX_INT_STATUS) ?
                                           (wd & INT_W1C_MASK) : INT_RST));
      next_int_sts[BIT_L1_SUM] = |(set1 & ~chg1);
      next_int_sts[BIT_L2_SUM] = |(set2 & ~chg2);
      if (!sink_alone) begin
         next_int_sts[BIT_PULLUP] = 1'b0;
      end
   end

   // ********************************************************
   // Avalon-MM slave
   // ********************************************************
   always_comb begin
      next_int_mask = int_mask;
      next_ctl = ctl;
      next_dbclr1 = dbclr1;
      next_dbclr2 = dbclr2;
      next_hit_deb = hit_deb;
      next_msg_deb = msg_deb;
      next_ack = (avs_read | avs_write) & ~ack;
      next_rdata = rdata;
      if (wr_hit) begin
         case (idx)
            IDX_INT_MASK: next_int_mask = wd;
            IDX_CONTROL: next_ctl = wd[7:0];
            IDX_L1_DBCLR: next_dbclr1 = wd[7:0];
            IDX_L2_DBCLR: next_dbclr2 = wd[7:0];
            IDX_HIT_DEB: next_hit_deb = wd[7:0];
            IDX_MSG_DEB: next_msg_deb = wd[7:0];
            default: next_ctl = ctl;
         endcase
      end
      if (rd_hit) begin
         case (idx)
            IDX_INT_STATUS: next_rdata = {16'h0000, int_sts};
            IDX_L1_CHANGE: next_rdata = {24'h000000, chg1};
            IDX_L2_CHANGE: next_rdata = {24'h000000, chg2};
            IDX_L1_HITS: next_rdata = {24'h000000, hits.line1};
            IDX_L2_HITS: next_rdata = {24'h000000, hits.line2};
            IDX_INT_MASK: next_rdata = {16'h0000, int_mask};
            IDX_CONTROL: next_rdata = {24'h000000, ctl};
            IDX_L1_DBCLR: next_rdata = {24'h000000, dbclr1};
            IDX_L2_DBCLR: next_rdata = {24'h000000, dbclr2};
            IDX_HIT_DEB: next_rdata = {24'h000000, hit_deb};
            IDX_MSG_DEB: next_rdata = {24'h000000, msg_deb};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign avs_readdata = rdata;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         int_sts <= INT_RST;
         int_mask <= INT_RST;
         ctl <= BYTE_ZERO;
         dbclr1 <= BYTE_ZERO;
         dbclr2 <= BYTE_ZERO;
         hit_deb <= BYTE_ZERO;
         msg_deb <= BYTE_ZERO;
         chg1 <= CHG_RST;
         chg2 <= CHG_RST;
         hits <= {HITS_RST_SNK, HITS_RST_SNK};
         seen_valid <= 1'b0;
         rdata <= 32'h00000000;
         ack <= 1'b0;
         unit_cnt <= 32'h0;
         tick_cnt <= 8'h00;
         irq <= 1'b0;
      end else if (clk_en) begin
         int_sts <= next_int_sts;
         int_mask <= next_int_mask;
         ctl <= next_ctl;
         dbclr1 <= next_dbclr1;
         dbclr2 <= next_dbclr2;
         hit_deb <= next_hit_deb;
         msg_deb <= next_msg_deb;
         chg1 <= next_chg1;
         chg2 <= next_chg2;
         hits <= next_hits;
         seen_valid <= next_seen_valid;
         rdata <= next_rdata;
         ack <= next_ack;
         unit_cnt <= next_unit_cnt;
         tick_cnt <= next_tick_cnt;
         irq <= |(next_int_sts & int_mask);
      end
   end

   // ********************************************************
   // Checks
   // ********************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn || !clk_en);

   chk_change_set1: assert property (
      ((hits.line1 != $past(hits.line1)) && $past(clk_en) && $past(active))
      |-> ((chg1 & (hits.line1 ^ $past(hits.line1))) == (hits.line1 ^ $past(hits.line1))))
      else $error("line one change bit missed");

   chk_change_set2: assert property (
      ((hits.line2 != $past(hits.line2)) && $past(clk_en) && $past(active))
      |-> ((chg2 & (hits.line2 ^ $past(hits.line2))) == (hits.line2 ^ $past(hits.line2))))
      else $error("line two change bit missed");

   chk_change_clear1: assert property (
      ($past(wr_hit) && ($past(idx) == IDX_L1_CHANGE) && $past(clk_en))
      |-> ((chg1 & $past(wd[7:0]) & ~$past(set1)) == BYTE_ZERO))
      else $error("line one change bit not cleared");

   chk_change_clear2: assert property (
      ($past(wr_hit) && ($past(idx) == IDX_L2_CHANGE) && $past(clk_en))
      |-> ((chg2 & $past(wd[7:0]) & ~$past(set2)) == BYTE_ZERO))
      else $error("line two change bit not cleared");

   chk_valid_once: assert property (
      $past(seen_valid)
      |-> !(int_sts[BIT_VALID] && !$past(int_sts[BIT_VALID])))
      else $error("valid flag set a second time");

   chk_pullup_zero: assert property (
      (!$past(sink_alone) && $past(clk_en))
      |-> !int_sts[BIT_PULLUP])
      else $error("pullup change flag set outside standalone sink");

   chk_pullup_event: assert property (
      ($past(sink_alone) && $past(evt_pulse.pullup_change) && $past(clk_en))
      |-> int_sts[BIT_PULLUP])
      else $error("pullup change event lost");

   chk_detach_event: assert property (
      ($past(standalone) && $past(evt_pulse.detach) && $past(clk_en))
      |-> int_sts[BIT_DETACH])
      else $error("detach event lost");

   chk_attach_event: assert property (
      ($past(standalone) && $past(evt_pulse.attach) && $past(clk_en))
      |-> int_sts[BIT_ATTACH])
      else $error("attach event lost");

   chk_summary_line1: assert property (
      int_sts[BIT_L1_SUM]
      |-> ((chg1 & ~$past(chg1)) != BYTE_ZERO))
      else $error("line one summary without new change");

   chk_summary_line2: assert property (
      int_sts[BIT_L2_SUM]
      |-> ((chg2 & ~$past(chg2)) != BYTE_ZERO))
      else $error("line two summary without new change");

   chk_hits_inactive: assert property (
      (!$past(active) && $past(clk_en))
      |-> (hits.line1 == ($past(role_src) ? HITS_RST_SRC : HITS_RST_SNK)))
      else $error("inactive hits not at reset value");

   chk_update_timed: assert property (
      update
      |-> (tick && active && !hold))
      else $error("hits updated off the debounce tick");

   chk_wait_short: assert property (
      avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus answer late");

   chk_irq_level: assert property (
      $past(clk_en)
      |-> (irq == |(int_sts & $past(int_mask))))
      else $error("interrupt level wrong");

   chk_readdata_hold: assert property (
      (!$past(rd_hit) && $past(clk_en))
      |-> $stable(avs_readdata))
      else $error("read data moved without a read");

   // ********************************************************
   // Coverage
   // ********************************************************
   cov_first_valid: cover property (
      int_sts[BIT_VALID]);
   cov_attach_seen: cover property (
      int_sts[BIT_ATTACH]);
   cov_wait_hold: cover property (
      (st == ccmse_attach_wait) && hold);
   cov_attached_update: cover property (
      (st == ccmse_attached) && update);
   cov_clear_meets_set: cover property (
      wr_hit && (idx == IDX_L1_CHANGE) && (set1 != BYTE_ZERO));
endmodule

//--- src/ccmse_pkg.sv
package ccmse_pkg;
   // ********************************************************
   // Register map (word index, byte address = 4 * index)
   // ********************************************************
   localparam logic [11:0] IDX_INT_STATUS = 12'h803;
   localparam logic [11:0] IDX_L1_CHANGE = 12'h804;
   localparam logic [11:0] IDX_L2_CHANGE = 12'h805;
   localparam logic [11:0] IDX_L1_HITS = 12'h806;
   localparam logic [11:0] IDX_L2_HITS = 12'h807;
   localparam logic [11:0] IDX_INT_MASK = 12'h810;
   localparam logic [11:0] IDX_CONTROL = 12'h811;
   localparam logic [11:0] IDX_L1_DBCLR = 12'h812;
   localparam logic [11:0] IDX_L2_DBCLR = 12'h813;
   localparam logic [11:0] IDX_HIT_DEB = 12'h814;
   localparam logic [11:0] IDX_MSG_DEB = 12'h815;
   localparam int ADDR_W = 14;

   // ********************************************************
   // Interrupt status bit positions
   // ********************************************************
   localparam int BIT_VALID = 7;
   localparam int BIT_PULLUP = 6;
   localparam int BIT_DETACH = 5;
   localparam int BIT_ATTACH = 4;
   localparam int BIT_L2_SUM = 1;
   localparam int BIT_L1_SUM = 0;
   localparam logic [15:0] INT_W1C_MASK = 16'h00f0;

   // ********************************************************
   // Control bit positions
   // ********************************************************
   localparam int CTL_COMP_EN = 0;
   localparam int CTL_STANDALONE = 1;
   localparam int CTL_ROLE_SRC = 2;
   localparam int CTL_UNIT_FINE = 3;

   // ********************************************************
   // Reset values
   // ********************************************************
   localparam logic [7:0] HITS_RST_SRC = 8'hff;
   localparam logic [7:0] HITS_RST_SNK = 8'h00;
   localparam logic [15:0] INT_RST = 16'h0000;
   localparam logic [7:0] CHG_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ********************************************************
   // Timing
   // ********************************************************
   localparam int CLK_MHZ = 200;
   localparam int UNIT_COARSE_US = 1600;
   localparam int UNIT_FINE_US = 100;
   localparam int UNIT_COARSE_CYC = UNIT_COARSE_US * CLK_MHZ;
   localparam int UNIT_FINE_CYC = UNIT_FINE_US * CLK_MHZ;
   localparam int MSG_UNIT_CYC = UNIT_FINE_CYC;

   typedef enum {ccmse_unattached, ccmse_attach_wait, ccmse_attached} ccmse_state_t;

   typedef struct packed {
      logic [7:0] line1;
      logic [7:0] line2;
   } ccmse_lines_t;

   typedef struct packed {
      logic attach;
      logic detach;
      logic pullup_change;
      logic open_seen;
   } ccmse_link_t;
endpackage

//--- dv/ccmse_partner.sv
module ccmse_partner
   import ccmse_pkg::*;
(
   input wire logic mclk,
   output ccmse_lines_t comp_raw,
   output ccmse_link_t link_evt,
   output logic [1:0] link_state
);
   // ****************************************
   // Line levels and link events
   // ****************************************
   initial begin
      comp_raw = '0;
      link_evt = '0;
      link_state = 2'h0;
   end

   // Comparator levels as seen on both lines
   task automatic set_lines(input logic [7:0] l1, input logic [7:0] l2);
      @(posedge mclk);
      comp_raw <= '{line1: l1, line2: l2};
   endtask

   // Attachment state of the far side
   task automatic set_state(input logic [1:0] s);
      @(posedge mclk);
      link_state <= s;
   endtask

   // Open line level seen while waiting for attach
   task automatic set_open(input logic v);
      @(posedge mclk);
      link_evt.open_seen <= v;
   endtask

   // Events are short level pulses, rising edge marks the event
   task automatic pulse(input ccmse_link_t e);
      @(posedge mclk);
      link_evt <= e;
      repeat (4) @(posedge mclk);
      link_evt <= '0;
   endtask
endmodule

//--- dv/ccmse_top_tb.sv
module ccmse_top_tb;
   import ccmse_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk;
   logic rstn;
   logic [ADDR_W-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   ccmse_lines_t comp_raw;
   ccmse_link_t link_evt;
   logic [1:0] link_state;
   logic irq;
   int err_count;
   int total_checks;
   int cyc;
   logic [31:0] rd;

   // ****************************************
   // Design and partner
   // ****************************************
   ccmse_top #(.COARSE_CYC(4), .FINE_CYC(2), .MSG_CYC(2)) DUT (
      .mclk(mclk), .rstn(rstn), .clk_en(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .comp_raw(comp_raw), .link_evt(link_evt), .link_state(link_state), .irq(irq)
   );
   ccmse_partner partner (
      .mclk(mclk), .comp_raw(comp_raw), .link_evt(link_evt), .link_state(link_state)
   );

   // ****************************************
   // Clock, timeout, shared tasks
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is seen low at a falling edge
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [15:0] d);
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(negedge mclk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      @(posedge mclk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 16'h0000);
      chk(rd, exp);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rd_chk(IDX_INT_STATUS, 32'h00000000);
      rd_chk(IDX_L1_CHANGE, 32'h00000000);
      rd_chk(IDX_L1_HITS, 32'h00000000);
      rd_chk(IDX_L2_HITS, 32'h00000000);
      rd_chk(12'h7ff, 32'h00000000);
      bus(1'b1, IDX_CONTROL, 16'h0004);
      rd_chk(IDX_L1_HITS, 32'h000000ff);
      rd_chk(IDX_L2_HITS, 32'h000000ff);
      bus(1'b1, IDX_CONTROL, 16'h0000);
   endtask

   task automatic t_raw_hits();
      partner.set_lines(8'h5a, 8'h3c);
      repeat (8) @(posedge mclk);
      rd_chk(IDX_L1_HITS, 32'h00000000);
      bus(1'b1, IDX_CONTROL, 16'h0001);
      repeat (8) @(posedge mclk);
      rd_chk(IDX_L1_HITS, 32'h0000005a);
      rd_chk(IDX_L2_HITS, 32'h0000003c);
      rd_chk(IDX_L1_CHANGE, 32'h0000005a);
      rd_chk(IDX_L2_CHANGE, 32'h0000003c);
      rd_chk(IDX_INT_STATUS, 32'h00000080);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, IDX_L1_CHANGE, 16'h0001);
      rd_chk(IDX_L1_CHANGE, 32'h0000005a);
      bus(1'b1, IDX_L1_CHANGE, 16'h0002);
      rd_chk(IDX_L1_CHANGE, 32'h00000058);
      bus(1'b1, IDX_L2_CHANGE, 16'h0000);
      rd_chk(IDX_L2_CHANGE, 32'h0000003c);
   endtask

   task automatic t_debounce();
      bus(1'b1, IDX_HIT_DEB, 16'h0008);
      bus(1'b1, IDX_L1_DBCLR, 16'h00ff);
      partner.set_lines(8'h0f, 8'h3c);
      rd_chk(IDX_L1_HITS, 32'h0000005a);
      repeat (60) @(posedge mclk);
      rd_chk(IDX_L1_HITS, 32'h0000000f);
      rd_chk(IDX_L1_CHANGE, 32'h0000005d);
   endtask

   task automatic t_events();
      bus(1'b1, IDX_CONTROL, 16'h0002);
      bus(1'b1, IDX_INT_STATUS, 16'h00f0);
      partner.pulse('{attach: 1'b1, detach: 1'b0, pullup_change: 1'b0, open_seen: 1'b0});
      partner.pulse('{attach: 1'b0, detach: 1'b1, pullup_change: 1'b0, open_seen: 1'b0});
      partner.pulse('{attach: 1'b0, detach: 1'b0, pullup_change: 1'b1, open_seen: 1'b0});
      repeat (4) @(posedge mclk);
      rd_chk(IDX_INT_STATUS, 32'h00000070);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, IDX_INT_MASK, 16'h00f0);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, IDX_INT_STATUS, 16'h0070);
      repeat (8) @(posedge mclk);
      rd_chk(IDX_INT_STATUS, 32'h00000000);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, IDX_CONTROL, 16'h0006);
      partner.pulse('{attach: 1'b0, detach: 1'b0, pullup_change: 1'b1, open_seen: 1'b0});
      repeat (4) @(posedge mclk);
      rd_chk(IDX_INT_STATUS, 32'h00000000);
   endtask

   task automatic t_states();
      bus(1'b1, IDX_MSG_DEB, 16'h0001);
      partner.set_state(2'h2);
      partner.set_lines(8'h33, 8'h3c);
      repeat (12) @(posedge mclk);
      rd_chk(IDX_L1_HITS, 32'h00000033);
      partner.set_state(2'h1);
      repeat (4) @(posedge mclk);
      partner.set_lines(8'h44, 8'h3c);
      repeat (20) @(posedge mclk);
      rd_chk(IDX_L1_HITS, 32'h00000033);
      partner.set_open(1'b1);
      repeat (12) @(posedge mclk);
      rd_chk(IDX_L1_HITS, 32'h00000044);
      partner.set_open(1'b0);
      partner.set_state(2'h0);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      err_count = 0;
      total_checks = 0;
      cyc = 0;
      rstn = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_raw_hits();
      t_debounce();
      t_events();
      t_states();
      wrap_up();
   end
endmodule
